// [bench/pwiu_top_assertions.sv]
// port checker for the word instruction unit
// assumes bind onto pwiu_top; single clock, synchronous reset
`timescale 1ns/100ps

module pwiu_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [9:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic FAULT,
  input wire logic CARRY,
  input wire logic ZERO,
  input wire logic BELOW,
  input wire logic ABOVE
);
  // ----
  // operand shadows, so flags can be tied to their cause
  // ----
  logic [15:0] opa_reg;
  logic [15:0] opb_reg;
  pwiu_pkg::pwiu_cmd_s cmd;

  function automatic logic isbcd(input logic [15:0] v);
    return v[15:12] < 4'ha && v[11:8] < 4'ha && v[7:4] < 4'ha && v[3:0] < 4'ha;
  endfunction : isbcd

  assign cmd = WDATA;
  wire cmd_wr = WR && ADDR == pwiu_pkg::OFS_CMD;
  wire dir = cmd_wr && cmd.exec_cond && !cmd.ind_a && !cmd.ind_b;
  wire bad_ptr = cmd_wr && cmd.exec_cond && cmd.ind_a && cmd.op == pwiu_pkg::OP_COPY
    && (!isbcd(opa_reg) || opa_reg > 16'h0063);
  wire add_bad = dir && cmd.op == pwiu_pkg::OP_ADD && !(isbcd(opa_reg) && isbcd(opb_reg));

  always_ff @(posedge CLK) begin
    if (RST) begin
      opa_reg <= 16'h0000;
      opb_reg <= 16'h0000;
    end else if (WR && ADDR == pwiu_pkg::OFS_OPA) begin
      opa_reg <= WDATA;
    end else if (WR && ADDR == pwiu_pkg::OFS_OPB) begin
      opb_reg <= WDATA;
    end
  end

  // ----
  // properties
  // ----
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence copy_run;
    dir && cmd.op == pwiu_pkg::OP_COPY;
  endsequence
  sequence inv_run;
    dir && cmd.op == pwiu_pkg::OP_COPY_INV;
  endsequence
  sequence result_read;
    RD && ADDR == pwiu_pkg::OFS_RESULT;
  endsequence

  a_copy_zero: assert property (
    copy_run |=> ZERO == (opa_reg == 16'h0000) && !FAULT)
    else $error("copy zero flag wrong");
  a_copy_data: assert property (
    copy_run ##[1:4] result_read |=> RDATA == opa_reg)
    else $error("copy result wrong");
  a_inv_data: assert property (
    inv_run ##[1:4] result_read |=> RDATA == ~opa_reg)
    else $error("inverted copy result wrong");
  a_cmp_flags: assert property (
    dir && cmd.op == pwiu_pkg::OP_COMPARE |=> ABOVE == (opa_reg > opb_reg)
      && ZERO == (opa_reg == opb_reg) && BELOW == (opa_reg < opb_reg))
    else $error("compare flags wrong");
  a_carry_clear: assert property (
    dir && cmd.op == pwiu_pkg::OP_CARRY_CLEAR |=> !CARRY)
    else $error("carry not cleared");
  a_cond_off: assert property (
    cmd_wr && !cmd.exec_cond && cmd.op != pwiu_pkg::OP_SHIFT
      |=> $stable({FAULT, CARRY, ZERO, BELOW, ABOVE}))
    else $error("flags moved with condition off");
  a_bad_ptr: assert property (
    bad_ptr |=> FAULT)
    else $error("bad pointer without fault");
  a_add_bad: assert property (
    add_bad |=> FAULT && $stable(CARRY))
    else $error("bad add digit mishandled");
  a_rdata_hold: assert property (
    !RD |=> $stable(RDATA))
    else $error("read data moved without read");
endmodule : pwiu_chk

bind pwiu_top pwiu_chk i_pwiu_chk (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .FAULT, .CARRY, .ZERO, .BELOW, .ABOVE);

// [bench/tb_top.sv]
// self-checking bench for the word instruction unit
// assumes pwiu_top with its checker bound; 50 MHz clock
`timescale 1ns/100ps

module tb_top;
  localparam logic [9:0] A_OPA = pwiu_pkg::OFS_OPA;
  localparam logic [9:0] A_OPB = pwiu_pkg::OFS_OPB;
  localparam logic [9:0] A_RES = pwiu_pkg::OFS_RESULT;
  localparam logic [9:0] A_FLG = pwiu_pkg::OFS_FLAGS;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [9:0] ADDR = 10'h000;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic FAULT, CARRY, ZERO, BELOW, ABOVE;
  wire logic [15:0] flg = {11'h000, FAULT, CARRY, ZERO, BELOW, ABOVE};
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] tbl [0:8] = '{16'h0002, 16'h0001, 16'h0002, 16'h0004, 16'h0002,
    16'h0100, 16'h0200, 16'h0000, 16'h9999};
  logic [15:0] pl [0:7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
    16'h0150, 16'h0200, 16'h0201};

  pwiu_top i_pwiu_top (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .FAULT, .CARRY, .ZERO, .BELOW, .ABOVE);

  always #10 CLK = ~CLK;

  // ----
  // hang guard: whole run needs under a thousand cycles
  // ----
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd

  // flags are registered on the command edge, so look just after it
  task automatic ex(input logic [15:0] c);
    wr(pwiu_pkg::OFS_CMD, c);
    #1;
  endtask : ex

  function automatic logic [15:0] fv(input logic f, y, z, l, g);
    return {11'h000, f, y, z, l, g};
  endfunction : fv

  function automatic int b2i(input logic [15:0] b);
    return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
  endfunction : b2i

  function automatic logic [15:0] i2b(input int v);
    return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction : i2b

  function automatic logic [15:0] rng(input logic [15:0] p);
    logic [15:0] r;
    logic [15:0] lo;
    logic [15:0] hi;
    r = 16'h0000;
    for (int k = 0; k <= tbl[0][3:0]; k++) begin
      lo = tbl[2 * k + 1];
      hi = tbl[2 * k + 2];
      r[k] = (lo <= hi) ? (p >= lo && p <= hi) : (p <= hi || p >= lo);
    end
    return r;
  endfunction : rng

  initial begin
    logic [15:0] a, b, d, ch;
    logic c, p, k, bi, cin;
    int s;
    void'($urandom(78105));
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(A_FLG, d);
    chk(d, 16'h0000);
    rd(10'h3fc, d);
    chk(d, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
      wr(A_OPA, a);
      ex(16'h0011);
      chk({15'h0, ZERO}, {15'h0, a == 16'h0000});
      rd(A_RES, d);
      chk(d, a);
      ex(16'h0012);
      chk({15'h0, ZERO}, {15'h0, a == 16'hffff});
      rd(A_RES, d);
      chk(d, ~a);
    end
    wr(A_OPA, 16'h1234);
    ex(16'h0001);
    rd(A_RES, d);
    chk(d, ~a);
    $display("copy test done");
    for (int i = 0; i < 10; i++) begin
      // compare values are raw random words, not decimal-coded
      a = (i == 2) ? 16'h4000 : 16'($urandom);
      b = (i < 2) ? a : (i == 2) ? 16'h5000 : 16'($urandom);
      wr(A_OPA, a);
      wr(A_OPB, b);
      ex(16'h0013);
      chk(flg, fv(1'b0, 1'b0, a == b, a < b, a > b));
    end
    rd(A_FLG, d);
    chk(d, {2'h0, a < b, 6'h00, a == b, a > b, 5'h00});
    $display("compare test done");
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 16'h9999 : (i == 1) ? 16'h0000 : i2b($urandom_range(9999));
      b = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0000 : i2b($urandom_range(9999));
      cin = (i < 2) ? 1'b0 : 1'($urandom);
      wr(A_FLG, {3'h0, cin, 12'h000});
      wr(A_OPA, a);
      wr(A_OPB, b);
      ex(16'h0016);
      s = b2i(a) + b2i(b) + cin;
      chk(flg, fv(1'b0, s > 9999, s % 10000 == 0, 1'b0, 1'b0));
      rd(A_RES, d);
      chk(d, i2b(s % 10000));
    end
    wr(A_OPA, 16'h00a0);
    ex(16'h0016);
    chk({15'h0, FAULT}, 16'h0001);
    rd(A_RES, d);
    chk(d, i2b(s % 10000));
    wr(A_FLG, 16'h1000);
    ex(16'h0005);
    chk({15'h0, CARRY}, 16'h0001);
    ex(16'h0015);
    chk({15'h0, CARRY}, 16'h0000);
    $display("add test done");
    wr(10'h10c, 16'h5a5a);
    for (int i = 0; i < 3; i++) begin
      wr(A_OPA, (i == 0) ? 16'h0064 : (i == 1) ? 16'h000a : 16'h0003);
      ex(16'h0031);
      chk({15'h0, FAULT}, {15'h0, i < 2});
    end
    rd(A_RES, d);
    chk(d, 16'h5a5a);
    // both operands through pointers to the same retained word
    wr(A_OPB, 16'h0003);
    ex(16'h0073);
    chk(flg, fv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    $display("indirect test done");
    for (int m = 0; m < 2; m++) begin
      tbl[0] = m ? 16'h0003 : 16'h0002;
      for (int j = 0; j < 9; j++) begin
        wr(10'(10'h200 + 4 * j), tbl[j]);
      end
      for (int i = 0; i < 12; i++) begin
        a = (i < 8) ? pl[i] : i2b($urandom_range(9999));
        wr(A_OPA, a);
        ex(16'h0014);
        rd(A_RES, d);
        chk(d, rng(a));
      end
    end
    $display("range test done");
    ch = 16'h0000;
    p = 1'b0;
    for (int i = 0; i < 40; i++) begin
      k = (i >= 20 && i < 23);
      c = 1'($urandom);
      bi = 1'($urandom);
      ex({2'h0, k, c, bi, 4'h5, 3'h0, 4'h7});
      if (k) ch = 16'h0000;
      else if (c && !p) ch = {ch[14:0], bi};
      p = c;
      rd(10'h094, d);
      chk(d, ch);
    end
    rd(10'h090, d);
    chk(d, 16'h0000);
    $display("shift test done");
    end_of_test();
  end
endmodule : tb_top

// [inc/pwiu_pkg.sv]
// constants, command layout and carriers of the word instruction unit
// assumes one 50 MHz clock; all users name items as pwiu_pkg::name

package pwiu_pkg;

  // ---------------------------------------------------------------
  // bus and storage geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CHAIN_COUNT = 16;
  localparam int unsigned RANGE_MAX = 10;
  localparam int unsigned TABLE_WORDS = 21;
  localparam int unsigned AREA_WORDS = 64;
  localparam int unsigned DIGITS = 4;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [9:0] OFS_OPA = 10'h000;
  localparam logic [9:0] OFS_OPB = 10'h004;
  localparam logic [9:0] OFS_CMD = 10'h008;
  localparam logic [9:0] OFS_RESULT = 10'h00c;
  localparam logic [9:0] OFS_FLAGS = 10'h010;
  // windows chosen by the top address bits
  localparam logic [3:0] CHAIN_REGION = 4'h2;
  localparam logic [1:0] AREA_REGION = 2'h1;
  localparam logic [1:0] TABLE_REGION = 2'h2;

  // ---------------------------------------------------------------
  // flag word: bits 11..13 mirror flag bits 0311..0313
  // ---------------------------------------------------------------
  localparam logic [15:0] FAULT_BIT_ADDR = 16'h0311;
  localparam logic [15:0] CARRY_BIT_ADDR = 16'h0312;
  localparam logic [15:0] BELOW_BIT_ADDR = 16'h0313;
  localparam int unsigned FLAG_FAULT_POS = 11;
  localparam int unsigned FLAG_CARRY_POS = 12;
  localparam int unsigned FLAG_BELOW_POS = 13;
  localparam int unsigned FLAG_ZERO_POS = 6;
  localparam int unsigned FLAG_ABOVE_POS = 5;

  // ---------------------------------------------------------------
  // reset values and decimal limits
  // ---------------------------------------------------------------
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic RESET_BIT = 1'b0;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [4:0] DIGIT_ADJ = 5'h06;
  localparam logic [6:0] AREA_LIMIT = 7'h40;
  localparam logic [6:0] TENS_WEIGHT = 7'h0a;

  // ---------------------------------------------------------------
  // opcodes and carriers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_COPY = 4'h1,
    OP_COPY_INV = 4'h2,
    OP_COMPARE = 4'h3,
    OP_RANGE = 4'h4,
    OP_CARRY_CLEAR = 4'h5,
    OP_ADD = 4'h6,
    OP_SHIFT = 4'h7
  } pwiu_op_e;

  typedef struct packed {
    logic [1:0] spare;
    logic shift_reset;
    logic shift_clock;
    logic shift_data;
    logic [3:0] chain_sel;
    logic ind_b;
    logic ind_a;
    logic exec_cond;
    pwiu_op_e op;
  } pwiu_cmd_s;

  typedef struct packed {
    logic carry;
    logic bad;
    logic [15:0] sum;
  } pwiu_add_s;

endpackage : pwiu_pkg

// [logic/pwiu_bcd_add.sv]
// four-digit decimal adder with carry in and carry out
// assumes operands are checked here; a bad digit only raises the bad bit
`timescale 1ns/100ps

module pwiu_bcd_add (
  input wire logic [15:0] augend,
  input wire logic [15:0] addend,
  input wire logic carry_in,
  output pwiu_pkg::pwiu_add_s out
);

  logic c;
  logic bad;
  logic [4:0] s;
  logic [3:0] da;
  logic [3:0] db;
  logic [15:0] sum;

  always_comb begin
    c = carry_in;
    bad = 1'b0;
    s = 5'h00;
    da = 4'h0;
    db = 4'h0;
    sum = pwiu_pkg::RESET_WORD;
    for (int i = 0; i < pwiu_pkg::DIGITS; i++) begin
      da = augend[4*i +: 4];
      db = addend[4*i +: 4];
      if ((da > pwiu_pkg::DIGIT_MAX) || (db > pwiu_pkg::DIGIT_MAX)) begin
        bad = 1'b1;
      end
      s = {1'b0, da} + {1'b0, db} + {4'h0, c};
      if (s > {1'b0, pwiu_pkg::DIGIT_MAX}) begin
        s = s + pwiu_pkg::DIGIT_ADJ;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      // only the low four digits survive, overflow lives in carry
      sum[4*i +: 4] = s[3:0];
    end
  end

  // one driver for the whole carrier: carry, bad, sum
  assign out = {c, bad, sum};

endmodule : pwiu_bcd_add

// [logic/pwiu_range_cmp.sv]
// one range slot of the range table comparison
// assumes decimal-coded operands, so plain unsigned order equals decimal order
`timescale 1ns/100ps

module pwiu_range_cmp (
  input wire logic [15:0] probe,
  input wire logic [15:0] lower,
  input wire logic [15:0] upper,
  output logic hit
);

  wire in_span = (probe >= lower) && (probe <= upper);
  wire out_span = (probe <= upper) || (probe >= lower);
  wire inverted = lower > upper;

  // equal limits count as a normal one-value range
  assign hit = inverted ? out_span : in_span;

endmodule : pwiu_range_cmp

// [logic/pwiu_top.sv]
// word instruction unit: shift chains, copies, compare, range table, carry clear, add
// assumes a bus master on CLK that never asserts RD and WR together
//
// Behaviour
// - shift loads data low, drops top bit
// - shift only on rising shift clock condition
// - chain reset clears and blocks shifting
// - condition off does nothing except shift; copy moves word
// - inverted copy writes bitwise complement
// - copy sets zero flag on zero result
// - copies repeat every execution while on
// - bad indirect pointer sets fault flag
// - compare sets exactly one of three flags
// - range count from base low digit
// - normal range sets bit when inside
// - inverted range sets bit when outside
// - table changes take effect at once
// - carry clear resets carry flag
// - add sums operands and carry, sets carry
// - non-decimal add operand sets fault flag
// - add sets zero flag on zero result
// - fault flag sits at bit 0311
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps

module pwiu_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [9:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic FAULT,
  output logic CARRY,
  output logic ZERO,
  output logic BELOW,
  output logic ABOVE
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] opa_reg;
  logic [15:0] opb_reg;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic [15:0] rdata_reg;
  logic fault_reg;
  logic fault_next;
  logic carry_reg;
  logic carry_next;
  logic zero_reg;
  logic zero_next;
  logic below_reg;
  logic below_next;
  logic above_reg;
  logic above_next;
  logic [15:0] chain_mem [pwiu_pkg::CHAIN_COUNT];
  logic [15:0] prev_clk_reg;
  logic [15:0] table_mem [pwiu_pkg::TABLE_WORDS];
  logic [15:0] area_mem [pwiu_pkg::AREA_WORDS];

  // ---------------------------------------------------------------
  // decimal helpers
  // ---------------------------------------------------------------
  function automatic logic is_bcd(input logic [15:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < pwiu_pkg::DIGITS; i++) begin
      if (w[4*i +: 4] > pwiu_pkg::DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_bcd

  // returns {valid, index}; a pointer must be decimal and inside the area
  function automatic logic [6:0] ptr_decode(input logic [15:0] p);
    logic [6:0] val;
    logic ok;
    val = (7'(p[7:4]) * pwiu_pkg::TENS_WEIGHT) + 7'(p[3:0]);
    ok = is_bcd(p) && (p[15:8] == 8'h00) && (val < pwiu_pkg::AREA_LIMIT);
    return {ok, val[5:0]};
  endfunction : ptr_decode

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire aligned = ADDR[1:0] == 2'b00;
  wire sel_opa = ADDR == pwiu_pkg::OFS_OPA;
  wire sel_opb = ADDR == pwiu_pkg::OFS_OPB;
  wire sel_cmd = ADDR == pwiu_pkg::OFS_CMD;
  wire sel_result = ADDR == pwiu_pkg::OFS_RESULT;
  wire sel_flags = ADDR == pwiu_pkg::OFS_FLAGS;
  wire sel_chain = aligned && (ADDR[9:6] == pwiu_pkg::CHAIN_REGION);
  wire sel_area = aligned && (ADDR[9:8] == pwiu_pkg::AREA_REGION);
  wire [4:0] table_idx = ADDR[6:2];
  wire sel_table = aligned && (ADDR[9:8] == pwiu_pkg::TABLE_REGION) && !ADDR[7]
    && (32'(table_idx) < pwiu_pkg::TABLE_WORDS);
  wire [3:0] chain_idx = ADDR[5:2];
  wire [5:0] area_idx = ADDR[7:2];

  // ---------------------------------------------------------------
  // instruction issue: a write to the command register executes once
  // ---------------------------------------------------------------
  pwiu_pkg::pwiu_cmd_s cmd;
  assign cmd = pwiu_pkg::pwiu_cmd_s'(WDATA);
  wire issue = WR && sel_cmd;
  wire cond_on = issue && cmd.exec_cond;

  // operand fetch, direct or through a retained-area pointer
  wire [6:0] ptr_a = ptr_decode(opa_reg);
  wire [6:0] ptr_b = ptr_decode(opb_reg);
  wire ok_a = !cmd.ind_a || ptr_a[6];
  wire ok_b = !cmd.ind_b || ptr_b[6];
  wire ind_fault = !(ok_a && ok_b);
  wire [15:0] a_val = cmd.ind_a ? area_mem[ptr_a[5:0]] : opa_reg;
  wire [15:0] b_val = cmd.ind_b ? area_mem[ptr_b[5:0]] : opb_reg;

  // ---------------------------------------------------------------
  // decimal add
  // ---------------------------------------------------------------
  pwiu_pkg::pwiu_add_s add_res;

  pwiu_bcd_add u_add (
    .augend(a_val),
    .addend(b_val),
    .carry_in(carry_reg),
    .out(add_res)
  );

  // ---------------------------------------------------------------
  // range table: compared against the live table contents
  // ---------------------------------------------------------------
  wire [3:0] base_digit = table_mem[0][3:0];
  wire [3:0] last_range = (base_digit > pwiu_pkg::DIGIT_MAX) ? pwiu_pkg::DIGIT_MAX : base_digit;
  logic [pwiu_pkg::RANGE_MAX-1:0] range_hit;
  logic [pwiu_pkg::RANGE_MAX-1:0] range_used;

  for (genvar k = 0; k < pwiu_pkg::RANGE_MAX; k++) begin : g_range
    pwiu_range_cmp u_rc (
      .probe(a_val),
      .lower(table_mem[2*k+1]),
      .upper(table_mem[2*k+2]),
      .hit(range_hit[k])
    );
    assign range_used[k] = 4'(k) <= last_range;
  end

  wire [15:0] range_word = {6'h00, range_hit & range_used};

  // ---------------------------------------------------------------
  // shift chains
  // ---------------------------------------------------------------
  wire shift_go = issue && (cmd.op == pwiu_pkg::OP_SHIFT);
  wire [15:0] chain_old = chain_mem[cmd.chain_sel];
  wire shift_rise = cmd.shift_clock && !prev_clk_reg[cmd.chain_sel];
  // a held reset wins over any clock edge seen during it
  wire [15:0] chain_new = cmd.shift_reset ? pwiu_pkg::RESET_WORD
    : shift_rise ? {chain_old[14:0], cmd.shift_data} : chain_old;

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < pwiu_pkg::CHAIN_COUNT; i++) begin
        chain_mem[i] <= pwiu_pkg::RESET_WORD;
      end
      prev_clk_reg <= pwiu_pkg::RESET_WORD;
    end else if (shift_go) begin
      chain_mem[cmd.chain_sel] <= chain_new;
      prev_clk_reg[cmd.chain_sel] <= cmd.shift_clock;
    end
  end

  // ---------------------------------------------------------------
  // instruction results and flags
  // ---------------------------------------------------------------
  always_comb begin
    result_next = result_reg;
    fault_next = fault_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    below_next = below_reg;
    above_next = above_reg;
    if (WR && sel_flags) begin
      fault_next = WDATA[pwiu_pkg::FLAG_FAULT_POS];
      carry_next = WDATA[pwiu_pkg::FLAG_CARRY_POS];
      zero_next = WDATA[pwiu_pkg::FLAG_ZERO_POS];
      below_next = WDATA[pwiu_pkg::FLAG_BELOW_POS];
      above_next = WDATA[pwiu_pkg::FLAG_ABOVE_POS];
    end else if (cond_on) begin
      case (cmd.op)
        pwiu_pkg::OP_COPY, pwiu_pkg::OP_COPY_INV: begin
          fault_next = ind_fault;
          if (!ind_fault) begin
            // copies act on each issued command, so a held condition repeats them
            result_next = (cmd.op == pwiu_pkg::OP_COPY) ? a_val : ~a_val;
            zero_next = ((cmd.op == pwiu_pkg::OP_COPY) ? a_val : ~a_val) == 16'h0000;
          end
        end
        pwiu_pkg::OP_COMPARE: begin
          fault_next = ind_fault;
          if (!ind_fault) begin
            above_next = a_val > b_val;
            zero_next = a_val == b_val;
            below_next = a_val < b_val;
          end
        end
        pwiu_pkg::OP_RANGE: begin
          fault_next = ind_fault;
          if (!ind_fault) begin
            result_next = range_word;
          end
        end
        pwiu_pkg::OP_CARRY_CLEAR: begin
          carry_next = 1'b0;
        end
        pwiu_pkg::OP_ADD: begin
          fault_next = ind_fault || add_res.bad;
          if (!ind_fault && !add_res.bad) begin
            result_next = add_res.sum;
            carry_next = add_res.carry;
            zero_next = add_res.sum == 16'h0000;
          end
        end
        default: begin
          result_next = result_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      result_reg <= pwiu_pkg::RESET_WORD;
      fault_reg <= pwiu_pkg::RESET_BIT;
      carry_reg <= pwiu_pkg::RESET_BIT;
      zero_reg <= pwiu_pkg::RESET_BIT;
      below_reg <= pwiu_pkg::RESET_BIT;
      above_reg <= pwiu_pkg::RESET_BIT;
    end else begin
      result_reg <= result_next;
      fault_reg <= fault_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      below_reg <= below_next;
      above_reg <= above_next;
    end
  end

  // ---------------------------------------------------------------
  // operand, table and retained-area writes
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      opa_reg <= pwiu_pkg::RESET_WORD;
      opb_reg <= pwiu_pkg::RESET_WORD;
    end else if (WR && sel_opa) begin
      opa_reg <= WDATA;
    end else if (WR && sel_opb) begin
      opb_reg <= WDATA;
    end
  end

  // table and retained area are plain memories: no reset, contents survive it
  always_ff @(posedge CLK) begin
    if (WR && sel_table) begin
      table_mem[table_idx] <= WDATA;
    end
    if (WR && sel_area) begin
      area_mem[area_idx] <= WDATA;
    end
  end

  // ---------------------------------------------------------------
  // read port: data stand in the cycle after the read strobe
  // ---------------------------------------------------------------
  wire [15:0] flags_word = (16'(fault_reg) << pwiu_pkg::FLAG_FAULT_POS)
    | (16'(carry_reg) << pwiu_pkg::FLAG_CARRY_POS)
    | (16'(below_reg) << pwiu_pkg::FLAG_BELOW_POS)
    | (16'(zero_reg) << pwiu_pkg::FLAG_ZERO_POS)
    | (16'(above_reg) << pwiu_pkg::FLAG_ABOVE_POS);

  wire [15:0] rd_mux = sel_opa ? opa_reg
    : sel_opb ? opb_reg
    : sel_result ? result_reg
    : sel_flags ? flags_word
    : sel_chain ? chain_mem[chain_idx]
    : sel_table ? table_mem[table_idx]
    : sel_area ? area_mem[area_idx]
    : 16'h0000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg <= pwiu_pkg::RESET_WORD;
    end else if (RD) begin
      rdata_reg <= rd_mux;
    end
  end

  assign RDATA = rdata_reg;
  assign FAULT = fault_reg;
  assign CARRY = carry_reg;
  assign ZERO = zero_reg;
  assign BELOW = below_reg;
  assign ABOVE = above_reg;

endmodule : pwiu_top
